// >>> verilog/flash_read_map.svh
`ifndef FLASH_READ_MAP_SVH
`define FLASH_READ_MAP_SVH
// ==========================================================
// command codes
`define FAST_READ_CMD 8'h0B
`define DUAL_OUTPUT_READ_CMD 8'h3B
`define QUAD_OUTPUT_READ_CMD 8'h6B
`define QUAD_IO_READ_CMD 8'hEB
`define QUAD_IO_WORD_READ_CMD 8'hE7
`define BURST_SETUP_CMD 8'hC0
`define ENHANCE_RESET_CMD 8'hFF
// ==========================================================
// phase lengths in serial clocks
`define SINGLE_CMD_CLKS 5'd8
`define QUAD_CMD_CLKS 5'd2
`define ADDR_CLKS_X1 5'd24
`define ADDR_CLKS_X2 5'd12
`define ADDR_CLKS_X4 5'd6
`define MODE_CLKS 5'd2
`define LONG_DUMMY_CLKS 5'd8
`define SHORT_DUMMY_CLKS 5'd4
`define BURST_CLKS_X1 5'd8
`define BURST_CLKS_X4 5'd2
// ==========================================================
// wrap configuration and memory
`define WRAP_BASE_BYTES 8'h08
`define WRAP_EN_RESET 1'b0
`define WRAP_DEPTH_RESET 2'b00
`define MEM_AW 12
`define MEM_DEPTH 4096
`endif

// >>> verilog/flash_read_pkg.sv
`default_nettype none
package flash_read_pkg;
   typedef enum logic [2:0] {
      ST_START, ST_CMD, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_WRAP, ST_IGNORE
   } state_t;
   typedef enum logic [1:0] {LANE1, LANE2, LANE4} lane_t;
endpackage : flash_read_pkg
`default_nettype wire

// >>> verilog/serial_flash_read_path.sv
`include "flash_read_map.svh"
`default_nettype none
module serial_flash_read_path #(
   parameter logic [7:0] basic_read_cmd = 8'h03,
   parameter logic [7:0] dual_io_read_cmd = 8'hBB
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic quad_enable,
   input wire logic quad_command_mode,
   input wire logic write_busy,
   input wire logic load_valid,
   input wire logic [`MEM_AW-1:0] load_addr,
   input wire logic [7:0] load_data,
   output logic wp_reset_pins_on,
   output logic continuous_mode,
   output logic wrap_enabled,
   output logic read_active,
   output logic read_rejected,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic data_line0_in,
   output logic data_line0_out,
   output logic data_line0_oe,
   input wire logic data_line1_in,
   output logic data_line1_out,
   output logic data_line1_oe,
   input wire logic data_line2_in,
   output logic data_line2_out,
   output logic data_line2_oe,
   input wire logic data_line3_in,
   output logic data_line3_out,
   output logic data_line3_oe
);
   import flash_read_pkg::*;

   // ==========================================================
   // system side: configuration capture and memory load
   logic qe_reg, qcm_reg, busy_reg, en_reg;
   logic [7:0] mem [0:`MEM_DEPTH-1];

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         qe_reg <= 1'b0;
         qcm_reg <= 1'b0;
         busy_reg <= 1'b0;
         en_reg <= 1'b0;
      end else begin
         en_reg <= clk_en;
         if (clk_en) begin
            qe_reg <= quad_enable;
            qcm_reg <= quad_command_mode;
            busy_reg <= write_busy;
         end
      end
   end

   // host keeps the link idle while loading
   always_ff @(posedge mclk) begin
      if (clk_en && load_valid) begin
         mem[load_addr] <= load_data;
      end
   end

   // ==========================================================
   // crossing into the serial clock domain
   logic [1:0] qe_sync, qcm_sync, busy_sync, en_sync;
   logic qe_s, qcm_s, busy_s, en_s;

   always_ff @(posedge sclk or negedge reset_n) begin
      if (!reset_n) begin
         qe_sync <= 2'b00;
         qcm_sync <= 2'b00;
         busy_sync <= 2'b00;
         en_sync <= 2'b00;
      end else begin
         qe_sync <= {qe_sync[0], qe_reg};
         qcm_sync <= {qcm_sync[0], qcm_reg};
         busy_sync <= {busy_sync[0], busy_reg};
         en_sync <= {en_sync[0], en_reg};
      end
   end

   assign qe_s = qe_sync[1];
   assign qcm_s = qcm_sync[1];
   assign busy_s = busy_sync[1];
   assign en_s = en_sync[1];

   // ==========================================================
   // command, address, mode and dummy phases (rising edge)
   logic frame_rst_n;
   logic [3:0] din;
   state_t state;
   logic [4:0] cnt, dummy_n;
   logic [7:0] sh, sh_nx;
   logic [23:0] addr_sh, addr_nx;
   lane_t aw, dw;
   logic has_mode, wrap_use, cont_path, ff_run;
   logic cont_reg, wrap_en_reg, rej_tgl;
   logic [1:0] wrap_dep_reg;

   // chip select high clears all frame state at once
   assign frame_rst_n = reset_n & ~cs_n;
   assign din = {data_line3_in, data_line2_in, data_line1_in, data_line0_in};

   always_comb begin
      if (state == ST_MODE || qcm_s) begin
         sh_nx = {sh[3:0], din};
      end else begin
         sh_nx = {sh[6:0], din[0]};
      end
      unique case (aw)
         LANE1: addr_nx = {addr_sh[22:0], din[0]};
         LANE2: addr_nx = {addr_sh[21:0], din[1:0]};
         default: addr_nx = {addr_sh[19:0], din};
      endcase
   end

   logic quad_ok, dec_ok, dec_mode, dec_wrap, dec_burst, dec_ff;
   lane_t dec_aw, dec_dw;
   logic [4:0] dec_dummy, dec_addr_clks;

   always_comb begin
      quad_ok = qe_s || qcm_s;
      dec_ok = 1'b0;
      dec_mode = 1'b0;
      dec_wrap = 1'b0;
      dec_burst = 1'b0;
      dec_ff = 1'b0;
      dec_aw = LANE1;
      dec_dw = LANE1;
      dec_dummy = 5'd0;
      if (sh_nx == basic_read_cmd) begin
         dec_ok = !qcm_s;
      end else if (sh_nx == `FAST_READ_CMD) begin
         dec_ok = 1'b1;
         dec_aw = qcm_s ? LANE4 : LANE1;
         dec_dw = qcm_s ? LANE4 : LANE1;
         dec_dummy = qcm_s ? `SHORT_DUMMY_CLKS : `LONG_DUMMY_CLKS;
         dec_wrap = qcm_s;
      end else if (sh_nx == `DUAL_OUTPUT_READ_CMD) begin
         dec_ok = !qcm_s;
         dec_dw = LANE2;
         dec_dummy = `LONG_DUMMY_CLKS;
      end else if (sh_nx == dual_io_read_cmd) begin
         dec_ok = !qcm_s;
         dec_aw = LANE2;
         dec_dw = LANE2;
         dec_dummy = `SHORT_DUMMY_CLKS;
      end else if (sh_nx == `QUAD_OUTPUT_READ_CMD) begin
         dec_ok = !qcm_s && qe_s;
         dec_dw = LANE4;
         dec_dummy = `LONG_DUMMY_CLKS;
      end else if (sh_nx == `QUAD_IO_READ_CMD || sh_nx == `QUAD_IO_WORD_READ_CMD) begin
         dec_ok = quad_ok && (sh_nx == `QUAD_IO_READ_CMD || !qcm_s);
         dec_aw = LANE4;
         dec_dw = LANE4;
         dec_mode = 1'b1;
         dec_dummy = `SHORT_DUMMY_CLKS;
         dec_wrap = 1'b1;
      end else if (sh_nx == `BURST_SETUP_CMD) begin
         dec_burst = 1'b1;
      end else if (sh_nx == `ENHANCE_RESET_CMD) begin
         dec_ff = 1'b1;
      end
      unique case (dec_aw)
         LANE1: dec_addr_clks = `ADDR_CLKS_X1;
         LANE2: dec_addr_clks = `ADDR_CLKS_X2;
         default: dec_addr_clks = `ADDR_CLKS_X4;
      endcase
   end

   logic cmd_done, mode_done, wrap_done, ff_done, rej_evt;
   assign cmd_done = en_s && state == ST_CMD && cnt == 5'd0;
   assign mode_done = en_s && state == ST_MODE && cnt == 5'd0;
   assign wrap_done = en_s && state == ST_WRAP && cnt == 5'd0;
   assign ff_done = (mode_done && cont_path && ff_run && din[0]) || (cmd_done && dec_ff);
   assign rej_evt = cmd_done && dec_ok && busy_s;

   always_ff @(posedge sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         state <= ST_START;
         cnt <= 5'd0;
         sh <= 8'h00;
         addr_sh <= 24'h00_0000;
         aw <= LANE1;
         dw <= LANE1;
         dummy_n <= 5'd0;
         has_mode <= 1'b0;
         wrap_use <= 1'b0;
         cont_path <= 1'b0;
         ff_run <= 1'b0;
      end else if (en_s) begin
         unique case (state)
            ST_START: begin
               if (cont_reg) begin
                  // first clock already carries address
                  addr_sh <= {addr_sh[19:0], din};
                  aw <= LANE4;
                  dw <= LANE4;
                  has_mode <= 1'b1;
                  wrap_use <= 1'b1;
                  dummy_n <= `SHORT_DUMMY_CLKS;
                  cont_path <= 1'b1;
                  ff_run <= din[0];
                  cnt <= `ADDR_CLKS_X4 - 5'd2;
                  state <= ST_ADDR;
               end else begin
                  sh <= sh_nx;
                  cnt <= (qcm_s ? `QUAD_CMD_CLKS : `SINGLE_CMD_CLKS) - 5'd2;
                  state <= ST_CMD;
               end
            end
            ST_CMD: begin
               sh <= sh_nx;
               if (cnt != 5'd0) begin
                  cnt <= cnt - 5'd1;
               end else if (dec_burst) begin
                  cnt <= (qcm_s ? `BURST_CLKS_X4 : `BURST_CLKS_X1) - 5'd1;
                  state <= ST_WRAP;
               end else if (dec_ok && !busy_s) begin
                  aw <= dec_aw;
                  dw <= dec_dw;
                  has_mode <= dec_mode;
                  wrap_use <= dec_wrap;
                  dummy_n <= dec_dummy;
                  cnt <= dec_addr_clks - 5'd1;
                  state <= ST_ADDR;
               end else begin
                  state <= ST_IGNORE;
               end
            end
            ST_ADDR: begin
               addr_sh <= addr_nx;
               ff_run <= ff_run & din[0];
               if (cnt != 5'd0) begin
                  cnt <= cnt - 5'd1;
               end else if (has_mode) begin
                  cnt <= `MODE_CLKS - 5'd1;
                  state <= ST_MODE;
               end else if (dummy_n != 5'd0) begin
                  cnt <= dummy_n - 5'd1;
                  state <= ST_DUMMY;
               end else begin
                  state <= ST_DATA;
               end
            end
            ST_MODE: begin
               sh <= sh_nx;
               ff_run <= ff_run & din[0];
               if (cnt != 5'd0) begin
                  cnt <= cnt - 5'd1;
               end else if (ff_done) begin
                  state <= ST_IGNORE;
               end else begin
                  cnt <= dummy_n - 5'd1;
                  state <= ST_DUMMY;
               end
            end
            ST_DUMMY: begin
               if (cnt != 5'd0) begin
                  cnt <= cnt - 5'd1;
               end else begin
                  state <= ST_DATA;
               end
            end
            ST_WRAP: begin
               sh <= sh_nx;
               if (cnt != 5'd0) begin
                  cnt <= cnt - 5'd1;
               end else begin
                  state <= ST_IGNORE;
               end
            end
            ST_DATA, ST_IGNORE: begin
               state <= state;
            end
         endcase
      end
   end

   // continuous read survives chip select, cleared by the mode byte or the FF opcode
   always_ff @(posedge sclk or negedge reset_n) begin
      if (!reset_n) begin
         cont_reg <= 1'b0;
      end else if (ff_done) begin
         cont_reg <= 1'b0;
      end else if (mode_done) begin
         cont_reg <= (sh_nx[7:4] == ~sh_nx[3:0]);
      end
   end

   always_ff @(posedge sclk or negedge reset_n) begin
      if (!reset_n) begin
         wrap_en_reg <= `WRAP_EN_RESET;
         wrap_dep_reg <= `WRAP_DEPTH_RESET;
      end else if (wrap_done) begin
         wrap_en_reg <= (sh_nx[7:4] == 4'h0);
         if (sh_nx[7:4] == 4'h0) begin
            wrap_dep_reg <= sh_nx[1:0];
         end
      end
   end

   always_ff @(posedge sclk or negedge reset_n) begin
      if (!reset_n) begin
         rej_tgl <= 1'b0;
      end else if (rej_evt) begin
         rej_tgl <= ~rej_tgl;
      end
   end

   // ==========================================================
   // data phase (falling edge)
   logic [3:0] dout_reg, doe_reg, lane_out, lane_oe, bits_left, step;
   logic [23:0] ptr, cur, nxt;
   logic [7:0] osh, osh_nx, src, byte_q, mask;
   logic started;

   always_comb begin
      cur = started ? ptr : addr_sh;
      byte_q = mem[cur[`MEM_AW-1:0]];
      mask = (`WRAP_BASE_BYTES << wrap_dep_reg) - 8'h01;
      if (wrap_use && wrap_en_reg) begin
         nxt = {cur[23:8], (cur[7:0] & ~mask) | ((cur[7:0] + 8'h01) & mask)};
      end else begin
         nxt = cur + 24'h00_0001;
      end
      src = (bits_left == 4'd0) ? byte_q : osh;
      unique case (dw)
         LANE1: begin
            lane_out = {2'b00, src[7], 1'b0};
            lane_oe = 4'b0010;
            osh_nx = {src[6:0], 1'b0};
            step = 4'd1;
         end
         LANE2: begin
            lane_out = {2'b00, src[7:6]};
            lane_oe = 4'b0011;
            osh_nx = {src[5:0], 2'b00};
            step = 4'd2;
         end
         default: begin
            lane_out = src[7:4];
            lane_oe = 4'b1111;
            osh_nx = {src[3:0], 4'h0};
            step = 4'd4;
         end
      endcase
   end

   always_ff @(negedge sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         dout_reg <= 4'h0;
         doe_reg <= 4'h0;
         ptr <= 24'h00_0000;
         osh <= 8'h00;
         bits_left <= 4'd0;
         started <= 1'b0;
      end else if (en_s && state == ST_DATA) begin
         dout_reg <= lane_out;
         doe_reg <= lane_oe;
         osh <= osh_nx;
         bits_left <= ((bits_left == 4'd0) ? 4'd8 : bits_left) - step;
         if (bits_left == 4'd0) begin
            ptr <= nxt;
            started <= 1'b1;
         end
      end
   end

   assign data_line0_out = dout_reg[0];
   assign data_line1_out = dout_reg[1];
   assign data_line2_out = dout_reg[2];
   assign data_line3_out = dout_reg[3];
   assign data_line0_oe = doe_reg[0];
   assign data_line1_oe = doe_reg[1];
   assign data_line2_oe = doe_reg[2];
   assign data_line3_oe = doe_reg[3];

   // ==========================================================
   // status back into the system domain
   logic [1:0] cont_sync, wrap_sync, act_sync, rej_sync;
   logic rej_seen;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cont_sync <= 2'b00;
         wrap_sync <= 2'b00;
         act_sync <= 2'b00;
         rej_sync <= 2'b00;
         rej_seen <= 1'b0;
         wp_reset_pins_on <= 1'b0;
         continuous_mode <= 1'b0;
         wrap_enabled <= 1'b0;
         read_active <= 1'b0;
         read_rejected <= 1'b0;
      end else if (clk_en) begin
         cont_sync <= {cont_sync[0], cont_reg};
         wrap_sync <= {wrap_sync[0], wrap_en_reg};
         act_sync <= {act_sync[0], started};
         rej_sync <= {rej_sync[0], rej_tgl};
         rej_seen <= rej_sync[1];
         wp_reset_pins_on <= ~qe_reg;
         continuous_mode <= cont_sync[1];
         wrap_enabled <= wrap_sync[1];
         read_active <= act_sync[1];
         read_rejected <= rej_sync[1] ^ rej_seen;
      end
   end
endmodule : serial_flash_read_path
`default_nettype wire

// >>> dv/serial_flash_read_path_chk.sv
`default_nettype none
module serial_flash_read_path_chk (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic quad_enable,
   input wire logic quad_command_mode,
   input wire logic write_busy,
   input wire logic cs_n,
   input wire logic wp_reset_pins_on,
   input wire logic continuous_mode,
   input wire logic wrap_enabled,
   input wire logic read_active,
   input wire logic read_rejected,
   input wire logic data_line0_oe,
   input wire logic data_line1_oe,
   input wire logic data_line2_oe,
   input wire logic data_line3_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);
   // ==========================================================
   // helpers
   logic [3:0] oe;
   logic [3:0] busy_cnt;
   assign oe = {data_line3_oe, data_line2_oe, data_line1_oe, data_line0_oe};
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         busy_cnt <= 4'h0;
      end else if (!write_busy) begin
         busy_cnt <= 4'h0;
      end else if (busy_cnt != 4'hf) begin
         busy_cnt <= busy_cnt + 4'h1;
      end
   end
   // ==========================================================
   // properties
   property p_idle_release;
      cs_n |-> oe == 4'h0;
   endproperty
   a_idle_release: assert property (p_idle_release)
      else $error("data lines driven while deselected");
   property p_dual_pair;
      data_line0_oe |-> data_line1_oe;
   endproperty
   a_dual_pair: assert property (p_dual_pair)
      else $error("line0 driven without line1");
   property p_quad_group;
      data_line2_oe || data_line3_oe |-> oe == 4'hf;
   endproperty
   a_quad_group: assert property (p_quad_group)
      else $error("quad lanes not driven together");
   property p_quad_gated;
      !quad_enable && !quad_command_mode |-> !data_line2_oe && !data_line3_oe;
   endproperty
   a_quad_gated: assert property (p_quad_gated)
      else $error("upper lines driven with quad off");
   property p_wp_on;
      !quad_enable [*4] |-> wp_reset_pins_on;
   endproperty
   a_wp_on: assert property (p_wp_on)
      else $error("pin functions off while quad disabled");
   property p_wp_off;
      quad_enable [*4] |-> !wp_reset_pins_on;
   endproperty
   a_wp_off: assert property (p_wp_off)
      else $error("pin functions on while quad enabled");
   property p_reject_pulse;
      $rose(read_rejected) |-> write_busy ##1 !read_rejected;
   endproperty
   a_reject_pulse: assert property (p_reject_pulse)
      else $error("reject pulse wrong");
   property p_busy_blocks;
      busy_cnt == 4'hf |-> !$rose(data_line1_oe);
   endproperty
   a_busy_blocks: assert property (p_busy_blocks)
      else $error("read served while busy");
   property p_end_read;
      $rose(cs_n) && read_active |-> ##[1:20] !read_active;
   endproperty
   a_end_read: assert property (p_end_read)
      else $error("read still active after deselect");
   property p_wrap_default;
      $rose(reset_n) |-> !wrap_enabled && !continuous_mode;
   endproperty
   a_wrap_default: assert property (p_wrap_default)
      else $error("wrap or continuous set after reset");
endmodule : serial_flash_read_path_chk
bind serial_flash_read_path serial_flash_read_path_chk chk (
   .mclk(mclk), .reset_n(reset_n), .quad_enable(quad_enable),
   .quad_command_mode(quad_command_mode), .write_busy(write_busy), .cs_n(cs_n),
   .wp_reset_pins_on(wp_reset_pins_on), .continuous_mode(continuous_mode),
   .wrap_enabled(wrap_enabled), .read_active(read_active), .read_rejected(read_rejected),
   .data_line0_oe(data_line0_oe), .data_line1_oe(data_line1_oe),
   .data_line2_oe(data_line2_oe), .data_line3_oe(data_line3_oe)
);
`default_nettype wire

// >>> dv/flash_host.sv
`default_nettype none
module flash_host (
   output logic sclk,
   output logic cs_n,
   output logic [3:0] hd,
   input wire logic [3:0] wire_lvl
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] rx_q[$];
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      hd = 4'h0;
   end
   // one link clock; lanes outside en toggle as a floating line would
   task automatic tick(input logic [3:0] v, input logic [3:0] en, output logic [3:0] s);
      hd = (v & en) | (~hd & ~en);
      #3 sclk = 1'b1;
      s = wire_lvl;
      #3 sclk = 1'b0;
   endtask : tick
   task automatic send8(input logic [7:0] b, input int l);
      logic [3:0] s;
      logic [3:0] m;
      m = 4'((1 << l) - 1);
      for (int i = 8 - l; i >= 0; i -= l) begin
         tick(4'(b >> i) & m, m, s);
      end
   endtask : send8
   // clocks with select high so the link side sees settled settings
   task automatic prime();
      logic [3:0] s;
      repeat (4) tick(4'h0, 4'h0, s);
   endtask : prime
   // ol 0 skips the opcode as in continuous mode
   task automatic frame(input logic [7:0] op, input int ol, input logic [23:0] a,
         input int al, input logic [7:0] md, input int ml, input int dc,
         input int dl, input int nb);
      logic [3:0] s;
      logic [7:0] b;
      cs_n = 1'b0;
      #3;
      if (ol > 0) send8(op, ol);
      for (int k = 2; k >= 0 && al > 0; k--) send8(a[k*8 +: 8], al);
      if (ml > 0) send8(md, ml);
      repeat (dc) tick(4'h0, 4'h0, s);
      rx_q = {};
      repeat (nb) begin
         for (int i = 0; i < 8; i += dl) begin
            tick(4'h0, 4'h0, s);
            b = (dl == 1) ? {b[6:0], s[1]} : (b << dl) | 8'(s & 4'((1 << dl) - 1));
         end
         rx_q.push_back(b);
      end
      cs_n = 1'b1;
      #6;
   endtask : frame
endmodule : flash_host
`default_nettype wire

// >>> dv/serial_flash_read_path_tb.sv
`include "flash_read_map.svh"
`default_nettype none
`define CHECK_EQ(got, exp) \
   begin \
      num_checks++; \
      if ((got) !== (exp)) begin \
         mismatches++; \
         $display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); \
      end \
   end
module serial_flash_read_path_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, reset_n, clk_en, quad_enable, quad_command_mode, write_busy, load_valid;
   logic [`MEM_AW-1:0] load_addr;
   logic [7:0] load_data;
   logic wp_reset_pins_on, continuous_mode, wrap_enabled, read_active, read_rejected;
   logic sclk, cs_n, oe_seen, cont, wrap_on, act_seen;
   logic [3:0] hd;
   wire logic [3:0] dout, doe;
   wire logic [3:0] lvl = (doe & dout) | (~doe & hd);
   logic [7:0] mem [`MEM_DEPTH];
   int mismatches, num_checks, cycles, rej_seen, wrap_sz;
   serial_flash_read_path DUT (
      .mclk, .reset_n, .clk_en, .quad_enable, .quad_command_mode, .write_busy,
      .load_valid, .load_addr, .load_data, .wp_reset_pins_on, .continuous_mode,
      .wrap_enabled, .read_active, .read_rejected, .sclk, .cs_n,
      .data_line0_in(lvl[0]), .data_line0_out(dout[0]), .data_line0_oe(doe[0]),
      .data_line1_in(lvl[1]), .data_line1_out(dout[1]), .data_line1_oe(doe[1]),
      .data_line2_in(lvl[2]), .data_line2_out(dout[2]), .data_line2_oe(doe[2]),
      .data_line3_in(lvl[3]), .data_line3_out(dout[3]), .data_line3_oe(doe[3])
   );
   flash_host host (.sclk, .cs_n, .hd, .wire_lvl(lvl));
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles++;
      rej_seen += (read_rejected === 1'b1);
      act_seen = act_seen | (read_active === 1'b1);
      if (cycles == 40000) begin
         mismatches++;
         tally_and_finish();
      end
   end
   always @(posedge sclk) oe_seen = oe_seen | (|doe);
   // ==========================================================
   // tasks
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : tally_and_finish
   task automatic settle();
      host.prime();
      repeat (8) @(negedge mclk);
   endtask : settle
   task automatic cfg(input logic qe, input logic qm, input logic bz);
      @(negedge mclk);
      quad_enable = qe;
      quad_command_mode = qm;
      write_busy = bz;
      settle();
      `CHECK_EQ(wp_reset_pins_on, ~qe)
   endtask : cfg
   task automatic rd(input logic [7:0] op, input int ol, input logic [23:0] a, input int al,
         input logic [7:0] md, input int ml, input int dc, input int dl, input int nb,
         input logic ok, input logic wr);
      logic [23:0] p;
      logic [23:0] msk;
      if (ol == 0) a[0] = 1'b0;
      p = a;
      msk = 24'(wrap_sz - 1);
      oe_seen = 1'b0;
      act_seen = 1'b0;
      host.frame(op, ol, a, al, md, ml, dc, dl, nb);
      if (ml > 0 && ok) cont = (md[7:4] === ~md[3:0]);
      settle();
      `CHECK_EQ(act_seen, ok)
      `CHECK_EQ(read_active, 1'b0)
      `CHECK_EQ(continuous_mode, cont)
      if (!ok) begin
         `CHECK_EQ(oe_seen, 1'b0)
      end else begin
         foreach (host.rx_q[i]) begin
            `CHECK_EQ(host.rx_q[i], mem[p[`MEM_AW-1:0]])
            p = (wr && wrap_on) ? (p & ~msk) | ((p + 24'h1) & msk) : p + 24'h1;
         end
      end
   endtask : rd
   task automatic burst(input logic [7:0] v, input int l);
      host.frame(8'hc0, l, 24'h0, 0, v, l, 0, 1, 0);
      wrap_on = (v[7:4] == 4'h0);
      wrap_sz = 8 << v[1:0];
      settle();
      `CHECK_EQ(wrap_enabled, wrap_on)
   endtask : burst
   // ==========================================================
   // main sequence
   initial begin
      {reset_n, quad_enable, quad_command_mode, write_busy, load_valid} = 5'h0;
      {load_addr, load_data, cont, wrap_on, oe_seen, act_seen} = '0;
      clk_en = 1'b1;
      wrap_sz = 8;
      void'($urandom(32'h74ac));
      repeat (3) @(negedge mclk);
      reset_n = 1'b1;
      cfg(1'b0, 1'b0, 1'b0);
      `CHECK_EQ(wrap_enabled, 1'b0)
      for (int i = 0; i < `MEM_DEPTH; i++) begin
         @(negedge mclk);
         load_valid = 1'b1;
         load_addr = `MEM_AW'(i);
         load_data = 8'($urandom);
         mem[i] = load_data;
      end
      @(negedge mclk);
      load_valid = 1'b0;
      rd(8'h03, 1, 24'hff_fffe, 1, 8'h00, 0, 0, 1, 4, 1, 0);
      rd(8'h0b, 1, 24'($urandom), 1, 8'h00, 0, 8, 1, 3, 1, 0);
      rd(8'h3b, 1, 24'($urandom), 1, 8'h00, 0, 8, 2, 3, 1, 0);
      rd(8'hbb, 1, 24'($urandom), 2, 8'h00, 0, 4, 2, 3, 1, 0);
      rd(8'h6b, 1, 24'($urandom), 1, 8'h00, 0, 8, 4, 2, 0, 0);
      cfg(1'b1, 1'b0, 1'b0);
      rd(8'h6b, 1, 24'($urandom), 1, 8'h00, 0, 8, 4, 3, 1, 0);
      rd(8'heb, 1, 24'($urandom), 4, 8'ha5, 4, 4, 4, 3, 1, 0);
      rd(8'h00, 0, 24'($urandom), 4, 8'h5a, 4, 4, 4, 3, 1, 0);
      rd(8'h00, 0, 24'($urandom), 4, 8'hff, 4, 4, 4, 3, 1, 0);
      rd(8'he7, 1, 24'($urandom), 4, 8'h0f, 4, 4, 4, 3, 1, 0);
      host.frame(8'hff, 1, 24'h0, 0, 8'h00, 0, 0, 1, 0);
      cont = 1'b0;
      settle();
      `CHECK_EQ(continuous_mode, 1'b0)
      for (int j = 0; j < 4; j++) begin
         burst(8'(j), 1);
         rd(8'heb, 1, 24'($urandom), 4, 8'h00, 4, 4, 4, (8 << j) + 2, 1, 1);
      end
      rd(8'h0b, 1, 24'($urandom), 1, 8'h00, 0, 8, 1, 10, 1, 0);
      burst(8'h10, 1);
      rd(8'heb, 1, 24'($urandom), 4, 8'h00, 4, 4, 4, 10, 1, 1);
      cfg(1'b1, 1'b0, 1'b1);
      rd(8'h0b, 1, 24'($urandom), 1, 8'h00, 0, 8, 1, 2, 0, 0);
      `CHECK_EQ(8'(rej_seen), 8'h01)
      cfg(1'b1, 1'b1, 1'b0);
      rd(8'h0b, 4, 24'($urandom), 4, 8'h00, 0, 4, 4, 3, 1, 0);
      rd(8'heb, 4, 24'($urandom), 4, 8'h00, 4, 4, 4, 3, 1, 0);
      rd(8'h03, 4, 24'($urandom), 4, 8'h00, 0, 0, 4, 2, 0, 0);
      burst(8'h01, 4);
      rd(8'h0b, 4, 24'($urandom), 4, 8'h00, 0, 4, 4, 18, 1, 1);
      tally_and_finish();
   end
endmodule : serial_flash_read_path_tb
`default_nettype wire
